// ---- pkg/exc_consts.svh ----
// Constants for the exception front end: vectors, field positions, reset values, timing
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH
`define VEC_RESET_PC 8'h00
`define VEC_RESET_SP 8'h01
`define VEC_ILLEGAL_GEN 8'h04
`define VEC_ILLEGAL_SLOT 8'h06
`define VEC_ADDR_ERROR 8'h09
`define VEC_NMI 8'h0b
`define VEC_TRAP_FIRST 8'h20
`define VEC_TRAP_LAST 8'h3f
`define VEC_EXT_IRQ_FIRST 8'h40
`define VEC_PERIPH_FIRST 8'h48
`define VEC_PERIPH_LAST 8'hff
`define VEC_ENTRY_BYTES 32'h00000004
`define VBR_RESET 32'h00000000
`define STATUS_RESET 32'h000000f0
`define IMASK_LSB 4
`define IMASK_MSB 7
`define IMASK_ALL_ONES 4'hf
`define STACK_STEP 32'h00000004
`define PERIPH_BASE 32'hffff8000
`define PERIPH_MASK 32'hffff8000
`define PERIPH_8BIT_MASK 32'hffffc000
`define PERIPH_8BIT_BASE 32'hffff8000
`define RESET_MIN_CYCLES 5'd20
`endif

// ---- pkg/exc_pkg.sv ----
// Types shared by the exception front end
package exc_pkg;
  // Access size of a bus cycle
  typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} access_size_t;
  // Bus request from the core
  typedef struct packed {
    logic valid;
    logic fetch;
    access_size_t size;
    logic [31:0] addr;
  } access_req_t;
  // Memory request issued by the exception unit
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
  // Sequencer states, Gray coded in declaration order
  typedef enum logic [3:0] {
    ST_HOLD = 4'b0000,
    ST_RST_PC = 4'b0001,
    ST_RST_SP = 4'b0011,
    ST_RUN = 4'b0010,
    ST_AE_WAIT = 4'b0110,
    ST_PUSH_SR = 4'b0111,
    ST_PUSH_PC = 4'b0101,
    ST_AE_VEC = 4'b0100,
    ST_RST_INIT = 4'b1100
  } seq_state_t;
endpackage

// ---- core/exc_unit.sv ----
// Exception front end: vector addressing, power-on reset sequence, address error handling
`timescale 1ns/1ps
`include "exc_consts.svh"
module exc_unit
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_power_on_clear_pin_n,
  input wire exc_pkg::access_req_t i_access,
  input wire logic i_insn_done,
  input wire logic [31:0] i_next_pc,
  input wire logic [31:0] i_status_word,
  input wire logic [31:0] i_general_reg_fifteen,
  input wire logic [7:0] i_vec_num,
  input wire logic i_vec_is_reset,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic [31:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output exc_pkg::mem_req_t o_mem,
  output logic o_access_abort,
  output logic o_core_hold,
  output logic o_load_pc,
  output logic [31:0] o_program_counter,
  output logic o_load_sp,
  output logic [31:0] o_stack_pointer,
  output logic [31:0] o_status_word,
  output logic [31:0] o_vector_base_reg,
  output logic [31:0] o_vec_addr,
  output logic o_addr_error_pending
);
  import exc_pkg::*;

  // Register map of the block's own registers
  localparam logic [31:0] ADDR_VBR = 32'h00000000;
  localparam logic [31:0] ADDR_STATE = 32'h00000004;

  // Two-stage synchroniser for the reset pin
  logic pin_meta;
  logic pin_sync;
  // Sequencer state
  seq_state_t state;
  // Low-time counter of the pin, saturating
  logic [4:0] low_count;
  // Pin was held low long enough
  logic low_ok;
  // Latched address error
  logic ae_flag;
  // Stack pointer working copy
  logic [31:0] sp_work;
  // Detected error for the current access
  logic ae_now;
  // Peripheral space decode
  logic in_periph;
  logic in_periph8;

  // Synchroniser, first stage read only by the second
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= i_power_on_clear_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // Count low time of the pin; the far side must keep it low twenty-one cycles
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      low_count <= 5'd0;
      low_ok <= 1'b0;
    end
    else if (!pin_sync)
    begin
      // Saturating count of the low period
      if (low_count != `RESET_MIN_CYCLES)
        low_count <= low_count + 5'd1;
      else
        low_ok <= 1'b1;
    end
    else if (state != ST_HOLD || !low_ok)
    begin
      // Qualification consumed once processing has begun; a short pulse leaves no partial count
      low_count <= 5'd0;
      low_ok <= 1'b0;
    end
  end

  // Address error decode
  always_comb
  begin
    in_periph = (i_access.addr & `PERIPH_MASK) == `PERIPH_BASE;
    in_periph8 = (i_access.addr & `PERIPH_8BIT_MASK) == `PERIPH_8BIT_BASE;
    ae_now = 1'b0;
    if (i_access.valid)
    begin
      if (i_access.fetch)
        ae_now = i_access.addr[0] || in_periph;
      else if (i_access.size == SZ_WORD)
        ae_now = i_access.addr[0];
      else if (i_access.size == SZ_LONG)
        ae_now = (i_access.addr[1:0] != 2'b00) || in_periph8;
    end
  end

  // Abort of the offending bus cycle and the pending flag
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_access_abort <= 1'b0;
      ae_flag <= 1'b0;
    end
    else if (!pin_sync)
    begin
      // Reset outranks any address error
      o_access_abort <= 1'b0;
      ae_flag <= 1'b0;
    end
    else
    begin
      o_access_abort <= ae_now && state == ST_RUN;
      // Set wins over the clear taken when stacking starts
      if (ae_now && state == ST_RUN)
        ae_flag <= 1'b1;
      else if (state == ST_AE_WAIT && i_insn_done)
        ae_flag <= 1'b0;
    end
  end

  // Main sequencer
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ST_HOLD;
      o_mem <= '0;
      o_load_pc <= 1'b0;
      o_load_sp <= 1'b0;
      o_program_counter <= 32'h00000000;
      o_stack_pointer <= 32'h00000000;
      o_status_word <= `STATUS_RESET;
      sp_work <= 32'h00000000;
      o_core_hold <= 1'b1;
    end
    else if (!pin_sync)
    begin
      // Pin low: initialise and hold the core
      state <= ST_HOLD;
      o_mem <= '0;
      o_load_pc <= 1'b0;
      o_load_sp <= 1'b0;
      o_program_counter <= 32'h00000000;
      o_stack_pointer <= 32'h00000000;
      o_status_word <= `STATUS_RESET;
      sp_work <= 32'h00000000;
      o_core_hold <= 1'b1;
    end
    else
    begin
      o_load_pc <= 1'b0;
      o_load_sp <= 1'b0;
      case (state)
        ST_HOLD:
        begin
          // Start only after a qualified low period
          if (low_ok)
          begin
            state <= ST_RST_PC;
            o_mem <= '{valid: 1'b1, write: 1'b0, addr: {24'h0, `VEC_RESET_PC} * `VEC_ENTRY_BYTES,
                       wdata: 32'h0};
          end
        end
        ST_RST_PC:
        begin
          // Initial program counter arrives
          if (i_mem_ack)
          begin
            o_program_counter <= i_mem_rdata;
            o_mem <= '{valid: 1'b1, write: 1'b0, addr: {24'h0, `VEC_RESET_SP} * `VEC_ENTRY_BYTES,
                       wdata: 32'h0};
            state <= ST_RST_SP;
          end
        end
        ST_RST_SP:
        begin
          // Initial stack pointer arrives
          if (i_mem_ack)
          begin
            o_stack_pointer <= i_mem_rdata;
            o_mem <= '0;
            state <= ST_RST_INIT;
          end
        end
        ST_RST_INIT:
        begin
          // Set mask to ones, load PC and SP, release core
          o_status_word[`IMASK_MSB:`IMASK_LSB] <= `IMASK_ALL_ONES;
          o_load_pc <= 1'b1;
          o_load_sp <= 1'b1;
          o_core_hold <= 1'b0;
          state <= ST_RUN;
        end
        ST_RUN:
        begin
          // Wait for an address error
          if (ae_now)
            state <= ST_AE_WAIT;
        end
        ST_AE_WAIT:
        begin
          // Let the current instruction finish, then stack status word
          if (i_insn_done)
          begin
            o_core_hold <= 1'b1;
            o_status_word <= i_status_word;
            sp_work <= i_general_reg_fifteen - `STACK_STEP;
            o_mem <= '{valid: 1'b1, write: 1'b1, addr: i_general_reg_fifteen - `STACK_STEP,
                       wdata: i_status_word};
            state <= ST_PUSH_SR;
          end
        end
        ST_PUSH_SR:
        begin
          // Status word written; push next PC
          if (i_mem_ack)
          begin
            sp_work <= sp_work - `STACK_STEP;
            o_mem <= '{valid: 1'b1, write: 1'b1, addr: sp_work - `STACK_STEP, wdata: i_next_pc};
            state <= ST_PUSH_PC;
          end
        end
        ST_PUSH_PC:
        begin
          // PC written; fetch address error vector
          if (i_mem_ack)
          begin
            o_stack_pointer <= sp_work;
            o_load_sp <= 1'b1;
            o_mem <= '{valid: 1'b1, write: 1'b0,
                       addr: o_vector_base_reg + {24'h0, `VEC_ADDR_ERROR} * `VEC_ENTRY_BYTES,
                       wdata: 32'h0};
            state <= ST_AE_VEC;
          end
        end
        ST_AE_VEC:
        begin
          // Jump straight to the handler, no delay slot
          if (i_mem_ack)
          begin
            o_program_counter <= i_mem_rdata;
            o_load_pc <= 1'b1;
            o_core_hold <= 1'b0;
            o_mem <= '0;
            state <= ST_RUN;
          end
        end
        default:
        begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  // Vector base register, cleared by reset, writable by software
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_vector_base_reg <= `VBR_RESET;
    else if (!pin_sync || state == ST_RST_INIT)
      o_vector_base_reg <= `VBR_RESET;
    else if (i_reg_wr && i_reg_addr == ADDR_VBR)
      o_vector_base_reg <= i_reg_wdata;
  end

  // Vector address for a requested number
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_vec_addr <= 32'h00000000;
    else if (i_vec_is_reset)
      o_vec_addr <= {24'h0, i_vec_num} * `VEC_ENTRY_BYTES;
    else
      o_vec_addr <= o_vector_base_reg + {24'h0, i_vec_num} * `VEC_ENTRY_BYTES;
  end

  // Pending flag output
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_addr_error_pending <= 1'b0;
    else
      o_addr_error_pending <= ae_flag;
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_reg_rdata <= 32'h00000000;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        ADDR_VBR: o_reg_rdata <= o_vector_base_reg;
        ADDR_STATE: o_reg_rdata <= {27'h0, ae_flag, state};
        default: o_reg_rdata <= 32'h00000000;
      endcase
    end
    else
      o_reg_rdata <= 32'h00000000;
  end
endmodule

// ---- tb/exc_unit_monitor.sv ----
// Checker for the exception front end ports
`timescale 1ns/1ps
`include "exc_consts.svh"
module exc_unit_monitor
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_power_on_clear_pin_n,
  input wire exc_pkg::access_req_t i_access,
  input wire logic i_insn_done,
  input wire logic [31:0] i_next_pc,
  input wire logic [31:0] i_status_word,
  input wire logic [31:0] i_general_reg_fifteen,
  input wire logic [7:0] i_vec_num,
  input wire logic i_vec_is_reset,
  input wire logic i_mem_ack,
  input wire exc_pkg::mem_req_t o_mem,
  input wire logic o_access_abort,
  input wire logic o_core_hold,
  input wire logic o_load_pc,
  input wire logic o_load_sp,
  input wire logic [31:0] o_vector_base_reg,
  input wire logic [31:0] o_status_word,
  input wire logic [31:0] o_vec_addr,
  input wire logic o_addr_error_pending
);
  import exc_pkg::*;
  // Core runs normally and may be aborted
  wire run = i_power_on_clear_pin_n && !o_core_hold && !o_addr_error_pending;
  // Accesses that must fault
  function automatic logic bad(access_req_t a);
    logic per = (a.addr & `PERIPH_MASK) == `PERIPH_BASE;
    logic p8 = (a.addr & `PERIPH_8BIT_MASK) == `PERIPH_8BIT_BASE;
    if (a.fetch)
      return a.addr[0] || per;
    return (a.size == SZ_WORD && a.addr[0]) || (a.size == SZ_LONG && (a.addr[1:0] != 2'b00 || p8));
  endfunction
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  // Status word push taken by memory
  sequence sr_push_s;
    o_mem.valid && o_mem.write && i_mem_ack && o_mem.addr == i_general_reg_fifteen - 32'h4;
  endsequence
  // Handler fetch of an address error: stack pointer loaded alone beside a read
  sequence hnd_s;
    o_load_sp && !o_load_pc && o_mem.valid && !o_mem.write;
  endsequence
  chk_vec_reset: assert property (i_vec_is_reset |=> o_vec_addr == {22'h0, $past(i_vec_num), 2'b00})
    else $error("reset vector address wrong");
  chk_vec_base: assert property (!i_vec_is_reset |=>
    o_vec_addr == $past(o_vector_base_reg) + {22'h0, $past(i_vec_num), 2'b00}) else $error("vector address wrong");
  chk_rst_load: assert property (o_load_pc && o_load_sp |-> o_status_word[7:4] == 4'hf && o_vector_base_reg == 0)
    else $error("reset load state wrong");
  chk_push_sr: assert property (sr_push_s |-> o_mem.wdata == i_status_word)
    else $error("status push wrong");
  chk_push_pc: assert property (sr_push_s |=> ##[0:1] (o_mem.valid && o_mem.write &&
    o_mem.addr == i_general_reg_fifteen - 32'h8 && o_mem.wdata == i_next_pc)) else $error("pc push wrong");
  chk_hnd_addr: assert property (hnd_s |-> o_mem.addr == o_vector_base_reg + 32'h24)
    else $error("handler fetch address wrong");
  chk_abort_bad: assert property (run && i_access.valid && bad(i_access) |=> o_access_abort)
    else $error("bad access not aborted");
  chk_abort_good: assert property (run && i_access.valid && !bad(i_access) |=> !o_access_abort)
    else $error("good access aborted");
  chk_ae_wait: assert property (o_access_abort ##1 !i_insn_done [*2] |-> !o_mem.valid)
    else $error("push before instruction end");
  chk_pin_init: assert property (!i_power_on_clear_pin_n [*4] |-> o_core_hold && !o_mem.valid)
    else $error("pin low did not initialise");
endmodule
bind exc_unit exc_unit_monitor i_mon (.*);

// ---- tb/mem_model.sv ----
// Memory model holding the vector table and taking stack pushes
`timescale 1ns/1ps
module mem_model
(
  input wire logic i_mclk,
  input wire exc_pkg::mem_req_t i_mem,
  input wire logic [2:0] i_lat,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [2:0] cnt = 3'h0; // Wait cycles spent on this request
  initial
  begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
  end
  // Answer after i_lat wait cycles; data bus toggles outside the answer
  always @(posedge i_mclk)
  begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    cnt <= 3'h0;
    if (i_mem.valid && !o_ack && cnt < i_lat)
      cnt <= cnt + 3'h1;
    else if (i_mem.valid && !o_ack)
    begin
      o_ack <= 1'b1;
      o_rdata <= i_mem.addr + 32'h1000; // Entry is its address plus 4 KiB
    end
  end
endmodule

// ---- tb/exc_unit_test.sv ----
// Self-checking bench for the exception front end
`timescale 1ns/1ps
module exc_unit_test;
  import exc_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, pin_n = 1'b0, done = 1'b0, visr = 1'b0, rwr = 1'b0, rrd = 1'b0;
  logic [7:0] vnum = 8'h00;
  logic [2:0] lat = 3'h0;
  logic [31:0] raddr = 32'h0, rwd = 32'h0, rdat, vaddr, pc, sp, sw, vector_base_reg, mrd;
  access_req_t acc = '0;
  mem_req_t mreq;
  logic ack, abort, hold, ldpc, ldsp, pend;
  int error_cnt = 0, tests_run = 0, k;
  logic [31:0] wa[2], wd[2];
  localparam logic [31:0] R15 = 32'h2000, NPC = 32'ha02, SW = 32'ha1, VB = 32'h100;
  logic [7:0] vt[12] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h09, 8'h0b, 8'h20, 8'h3f, 8'h40, 8'h47, 8'h48, 8'hff};
  always #10 clk = ~clk;
  exc_unit i_dut (.i_mclk(clk), .i_arst_n(arst_n), .i_power_on_clear_pin_n(pin_n), .i_access(acc),
    .i_insn_done(done), .i_next_pc(NPC), .i_status_word(SW), .i_general_reg_fifteen(R15), .i_vec_num(vnum),
    .i_vec_is_reset(visr), .i_mem_ack(ack), .i_mem_rdata(mrd), .i_reg_addr(raddr), .i_reg_wdata(rwd),
    .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdat), .o_mem(mreq), .o_access_abort(abort),
    .o_core_hold(hold), .o_load_pc(ldpc), .o_program_counter(pc), .o_load_sp(ldsp), .o_stack_pointer(sp),
    .o_status_word(sw), .o_vector_base_reg(vector_base_reg), .o_vec_addr(vaddr), .o_addr_error_pending(pend));
  mem_model i_mem (.i_mclk(clk), .i_mem(mreq), .i_lat(lat), .o_ack(ack), .o_rdata(mrd));
  // Count a comparison, report a difference
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Counts, verdict, stop
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Register write, then read with data in the next cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    raddr <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    raddr <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 chk("reg", rdat, e);
  endtask
  // Wait for a counter load, logging stack pushes
  task automatic wait_pc(input logic [31:0] e);
    k = 0;
    wa = '{32'h0, 32'h0};
    wd = wa;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      if ((mreq.valid && mreq.write && ack) === 1'b1 && k < 2)
      begin
        wa[k] = mreq.addr;
        wd[k] = mreq.wdata;
        k++;
      end
      if (ldpc === 1'b1)
        break;
    end
    chk("pc", pc, e);
  endtask
  // One core access; a faulting one runs through its handler
  task automatic access(input logic f, input access_size_t z, input logic [31:0] a, input logic bad);
    @(posedge clk);
    acc <= '{1'b1, f, z, a};
    @(posedge clk);
    acc <= '0;
    #1 chk("abort", 32'(abort), 32'(bad));
    if (bad)
    begin
      repeat (3) @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      wait_pc(VB + 32'h1024);
      chk("sr push", wa[0], R15 - 32'h4);
      chk("sr data", wd[0], SW);
      chk("pc push", wa[1], R15 - 32'h8);
      chk("pc data", wd[1], NPC);
      chk("sp", sp, R15 - 32'h8);
      chk("mask", 32'(sw[7:4]), 32'(SW[7:4]));
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (24) @(posedge clk);
    pin_n <= 1'b1;
    wait_pc(32'h1000);
    chk("sp", sp, 32'h1004);
    chk("vbr", vector_base_reg, 32'h0);
    chk("mask", 32'(sw[7:4]), 32'hf);
    wr(32'h0, VB);
    rd(32'h0, VB);
    rd(32'h4, 32'(ST_RUN));
    rd(32'h8, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk);
      vnum <= vt[i % 12];
      visr <= i < 12;
      @(posedge clk);
      #1 chk("vector", vaddr, (i < 12 ? 32'h0 : VB) + 32'(vt[i % 12]) * 32'h4);
    end
    access(1'b1, SZ_WORD, 32'h00000100, 1'b0);
    access(1'b1, SZ_WORD, 32'h00000101, 1'b1);
    lat <= 3'h3;
    access(1'b1, SZ_WORD, 32'hffff8100, 1'b1);
    access(1'b0, SZ_WORD, 32'h00000202, 1'b0);
    access(1'b0, SZ_WORD, 32'h00000203, 1'b1);
    access(1'b0, SZ_LONG, 32'h00000206, 1'b1);
    access(1'b0, SZ_LONG, 32'hffff8004, 1'b1);
    access(1'b0, SZ_LONG, 32'hffffc004, 1'b0);
    access(1'b0, SZ_BYTE, 32'hffff8001, 1'b0);
    // Reset arrives while an address error waits
    @(posedge clk);
    acc <= '{1'b1, 1'b0, SZ_LONG, 32'h00000301};
    @(posedge clk);
    acc <= '0;
    pin_n <= 1'b0;
    repeat (24) @(posedge clk);
    #1 chk("pend", 32'(pend), 32'h0);
    @(posedge clk);
    pin_n <= 1'b1;
    wait_pc(32'h1000);
    chk("vbr", vector_base_reg, 32'h0);
    chk("mask", 32'(sw[7:4]), 32'hf);
    // Two short pulses must neither start a sequence nor add up
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (12) @(posedge clk);
      pin_n <= 1'b1;
      repeat (12) @(posedge clk);
      #1 chk("start", 32'(mreq.valid), 32'h0);
    end
    finish_test;
  end
  // Cut a hang short
  initial
  begin
    #300us;
    error_cnt++;
    finish_test;
  end
endmodule
